/* verilog/swr_pkg.sv */
/*
  swr_pkg: constants, types and timing helpers for the single-wire
  reset and bit-slot engine.
  assumes a 40 MHz system clock; times are kept in ps, ns and in quarter-us units.
*/
package swr_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] SWR_OFS_CMD = 8'h00;
  localparam logic [7:0] SWR_OFS_STATUS = 8'h04;
  localparam logic [7:0] SWR_OFS_CONFIG = 8'h08;
  localparam logic [7:0] SWR_OFS_PORTCFG = 8'h0c;
  localparam logic [7:0] SWR_OFS_RDPTR = 8'h10;
  localparam logic [7:0] SWR_OFS_PTRDATA = 8'h14;
  localparam logic [7:0] SWR_OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] SWR_OFS_IRQ_MASK = 8'h1c;

  // ----------------------------------------------------------------
  // command codes and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] SWR_CMD_RESET = 8'hb4;
  localparam logic [7:0] SWR_CMD_BIT = 8'h87;
  localparam int SWR_CMD_PARAM_LSB = 8;
  localparam int SWR_BIT_VALUE_POS = 15;

  // status bits
  localparam int SWR_ST_BUSY = 0;
  localparam int SWR_ST_PRESENCE = 1;
  localparam int SWR_ST_SHORT = 2;
  localparam int SWR_ST_ACK = 4;
  localparam int SWR_ST_SBR = 5;

  // config bits
  localparam int SWR_CFG_APU = 0;
  localparam int SWR_CFG_SPU = 2;
  localparam int SWR_CFG_OVD = 3;
  localparam logic [2:0] SWR_CFG_RESET = 3'h0;

  // port parameter control byte
  localparam int SWR_PC_SEL_LSB = 5;
  localparam int SWR_PC_OD_POS = 4;
  localparam logic [2:0] SWR_SEL_RSTL = 3'h0;
  localparam logic [2:0] SWR_SEL_MSP = 3'h1;
  localparam logic [2:0] SWR_SEL_W0L = 3'h2;
  localparam logic [2:0] SWR_SEL_REC0 = 3'h3;
  localparam logic [2:0] SWR_SEL_WEAK_PULLUP_RESISTANCE = 3'h4;
  localparam logic [3:0] SWR_RSTL_RST = 4'h6;
  localparam logic [3:0] SWR_MSP_RST = 4'h6;
  localparam logic [3:0] SWR_W0L_RST = 4'h6;
  localparam logic [3:0] SWR_REC0_RST = 4'h6;
  localparam logic SWR_WEAK_PULLUP_RESISTANCE_RST = 1'b1;

  // irq bits
  localparam int SWR_IRQ_DONE = 0;
  localparam int SWR_IRQ_REFUSED = 1;
  localparam int SWR_IRQ_PRESENCE = 2;
  localparam int SWR_IRQ_SHORT = 3;
  localparam int SWR_IRQ_W = 4;

  // read pointer codes
  localparam logic [1:0] SWR_PTR_STATUS = 2'h0;
  localparam logic [1:0] SWR_PTR_CONFIG = 2'h1;
  localparam logic [1:0] SWR_PTR_PORTCFG = 2'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SWR_CLK_PERIOD_NS = 25;
  localparam int SWR_QUS_NS = 250;
  localparam int SWR_CYC_PER_QUS = SWR_QUS_NS / SWR_CLK_PERIOD_NS;
  localparam int SWR_START_LAT_PS = 262500;
  localparam int SWR_START_LAT_CYC = SWR_START_LAT_PS / (SWR_CLK_PERIOD_NS * 1000);
  localparam int SWR_SI_STD_NS = 8000;
  localparam int SWR_SI_OD_NS = 1000;
  localparam int SWR_MSR_STD_NS = 10000;
  localparam int SWR_MSR_OD_NS = 2000;
  localparam int SWR_W1L_STD_NS = 8000;
  localparam int SWR_W1L_OD_NS = 1000;
  localparam logic [11:0] SWR_SI_STD_Q = 12'(SWR_SI_STD_NS / SWR_QUS_NS);
  localparam logic [11:0] SWR_SI_OD_Q = 12'(SWR_SI_OD_NS / SWR_QUS_NS);
  localparam logic [11:0] SWR_MSR_STD_Q = 12'(SWR_MSR_STD_NS / SWR_QUS_NS);
  localparam logic [11:0] SWR_MSR_OD_Q = 12'(SWR_MSR_OD_NS / SWR_QUS_NS);
  localparam logic [11:0] SWR_W1L_STD_Q = 12'(SWR_W1L_STD_NS / SWR_QUS_NS);
  localparam logic [11:0] SWR_W1L_OD_Q = 12'(SWR_W1L_OD_NS / SWR_QUS_NS);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ovd;
    logic strong_pullup_enable;
    logic active_pullup_enable;
  } swr_cfg_t;

  typedef struct packed {
    logic [3:0] rstl;
    logic [3:0] msp;
    logic [3:0] w0l;
    logic [3:0] rec0;
    logic weak_pullup_resistance;
  } swr_tim_t;

  typedef enum logic [2:0] {
    SWR_IDLE = 3'b001,
    SWR_RESET = 3'b010,
    SWR_SLOT = 3'b100
  } swr_state_t;

  // ----------------------------------------------------------------
  // code to duration, quarter-us units
  // ----------------------------------------------------------------
  function automatic logic [11:0] swr_rstl_q(input logic [3:0] c, input logic od);
    logic [11:0] us;
    us = 12'd440 + 12'd20 * {8'h0, c};
    return od ? 12'(us * 12'd4 / 12'd10) : 12'(us * 12'd4);
  endfunction : swr_rstl_q

  function automatic logic [11:0] swr_msp_q(input logic [3:0] c, input logic od);
    logic [11:0] h;
    h = od ? 12'd10 + {8'h0, c} : 12'd56 + 12'd2 * {8'h0, c};
    if (od) begin
      h = (h < 12'd11) ? 12'd11 : ((h > 12'd22) ? 12'd22 : h);
      return 12'(h * 12'd2);
    end
    h = (h < 12'd58) ? 12'd58 : ((h > 12'd76) ? 12'd76 : h);
    return 12'(h * 12'd4);
  endfunction : swr_msp_q

  function automatic logic [11:0] swr_w0l_q(input logic [3:0] c, input logic od);
    logic [11:0] h;
    h = od ? 12'd10 + {8'h0, c} : 12'd52 + 12'd2 * {8'h0, c};
    if (od) begin
      return 12'(((h > 12'd20) ? 12'd20 : h) * 12'd2);
    end
    return 12'(((h > 12'd70) ? 12'd70 : h) * 12'd4);
  endfunction : swr_w0l_q

  function automatic logic [11:0] swr_rec0_q(input logic [3:0] c);
    logic [3:0] k;
    k = (c < 4'h5) ? 4'h5 : ((c > 4'he) ? 4'he : c);
    return 12'd11 + 12'd10 * {8'h0, k - 4'h5};
  endfunction : swr_rec0_q

endpackage : swr_pkg

/* verilog/swr_param_bank.sv */
/*
  swr_param_bank: standard and overdrive port timing codes and pullup select.
  assumes writes are already gated against a busy line by the caller.
*/
`timescale 1ns/1ps
module swr_param_bank import swr_pkg::*; (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [7:0] ctrl,
  input wire logic overdrive_speed_select,
  output swr_tim_t cur
);

  // ----------------------------------------------------------------
  // storage: index 0 reset-low, 1 presence sample, 2 write-zero low
  // ----------------------------------------------------------------
  logic [3:0] std_q [3];
  logic [3:0] od_q [3];
  logic [3:0] rec0_q;
  logic weak_pullup_resistance_q;
  logic [2:0] sel;
  logic speed_set_select;

  assign sel = ctrl[SWR_PC_SEL_LSB +: 3];
  assign speed_set_select = ctrl[SWR_PC_OD_POS];

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      std_q[0] <= SWR_RSTL_RST;
      std_q[1] <= SWR_MSP_RST;
      std_q[2] <= SWR_W0L_RST;
      od_q[0] <= SWR_RSTL_RST;
      od_q[1] <= SWR_MSP_RST;
      od_q[2] <= SWR_W0L_RST;
    end else if (clk_en && wr_en && sel < SWR_SEL_REC0) begin
      if (speed_set_select) begin // R17
        od_q[sel[1:0]] <= ctrl[3:0];
      end else begin
        std_q[sel[1:0]] <= ctrl[3:0];
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rec0_q <= SWR_REC0_RST;
      weak_pullup_resistance_q <= SWR_WEAK_PULLUP_RESISTANCE_RST;
    end else if (clk_en && wr_en) begin
      if (sel == SWR_SEL_REC0) begin
        rec0_q <= ctrl[3:0];
      end
      if (sel == SWR_SEL_WEAK_PULLUP_RESISTANCE) begin
        weak_pullup_resistance_q <= ctrl[0];
      end
    end
  end

  // current speed picks the active set
  always_comb begin
    cur.rstl = overdrive_speed_select ? od_q[0] : std_q[0];
    cur.msp = overdrive_speed_select ? od_q[1] : std_q[1];
    cur.w0l = overdrive_speed_select ? od_q[2] : std_q[2];
    cur.rec0 = rec0_q;
    cur.weak_pullup_resistance = weak_pullup_resistance_q;
  end

endmodule : swr_param_bank

/* verilog/swr_top.sv */
/*
  swr_top: reset/presence cycle and single time-slot engine on a single-wire
  line, with an APB register slave and one level interrupt.
  assumes an open-drain line with an external weak pullup; line_in is
  synchronous to clock; pclk is clock.
*/
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
// Contract
// (R01) command b4h, no parameter, starts a reset and presence cycle
// (R02) line sampled at short and presence points, results in two flags
// (R03) busy for twice reset-low; flags updated at reset-low plus sample times
// (R04) line activity starts within 262.5ns; command lasts twice reset-low
// (R05) reset code while busy is not acknowledged and ignored
// (R06) host should not enable strong pullup during a reset
// (R07) host waits for busy to clear before a new command
// (R08) after a reset the read pointer selects the status register
// (R09) commands use current speed, pullup and port timing values
// (R10) command 87h plus parameter byte makes exactly one time slot
// (R11) bit 7 of parameter picks write-zero or write-one/read slot
// (R12) line level at read-sample time stored in the bit result
// (R13) busy for one slot period; bit result updated at read-sample time
// (R14) slot activity starts within 262.5ns; command lasts one slot
// (R15) bit command while busy is not acknowledged and ignored
// (R16) after a bit command the read pointer selects the status register
// (R17) separate standard and overdrive timing sets, written by speed flag
// (R18) reset drives line low for reset-low, then releases for recovery
// (R19) presence or short flag set when line low at its sample point
module swr_top import swr_pkg::*; #(
  parameter int TW = 20,
  parameter int CYC_PER_QUS = SWR_CYC_PER_QUS
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic line_in,
  output logic line_out,
  output logic line_oe,
  output logic active_pullup_drive,
  output logic strong_pullup_drive,
  output logic weak_pullup_select,
  output logic irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [TW-1:0] cyc(input logic [11:0] q);
    return TW'(q * CYC_PER_QUS);
  endfunction : cyc

  function automatic logic reg_hit(input logic [7:0] a);
    return a == SWR_OFS_CMD || a == SWR_OFS_STATUS || a == SWR_OFS_CONFIG ||
           a == SWR_OFS_PORTCFG || a == SWR_OFS_RDPTR || a == SWR_OFS_PTRDATA ||
           a == SWR_OFS_IRQ_STAT || a == SWR_OFS_IRQ_MASK;
  endfunction : reg_hit

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  swr_state_t st_q;
  swr_cfg_t cfg_q;
  swr_tim_t cur;
  logic [TW-1:0] el_q;
  logic [TW-1:0] t_low_q;
  logic [TW-1:0] t_end_q;
  logic [TW-1:0] t_s1_q;
  logic [TW-1:0] t_s2_q;
  logic line_oe_q;
  logic presence_pulse_flag_q;
  logic short_detect_flag_q;
  logic single_bit_result_q;
  logic ack_q;
  logic [1:0] ptr_q;
  logic [SWR_IRQ_W-1:0] irq_stat_q;
  logic [SWR_IRQ_W-1:0] irq_mask_q;
  logic [SWR_IRQ_W-1:0] ev;
  logic [31:0] prdata_q;
  logic apu_q;
  logic spu_q;
  logic weak_pullup_resistance_q;
  logic line_busy_flag;
  logic wr_acc;
  logic cmd_wr;
  logic pc_wr;
  logic accept_rst;
  logic accept_bit;
  logic refuse;
  logic active;
  logic done;
  logic s1_hit;
  logic s2_hit;
  logic [7:0] code;
  logic bit_value;
  logic [31:0] status_w;
  logic [31:0] portcfg_w;
  logic [31:0] rd_w;
  logic [31:0] ptr_w;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign pready = clk_en;
  assign pslverr = psel && penable && !reg_hit(paddr);
  assign prdata = prdata_q;
  assign wr_acc = psel && penable && pwrite && clk_en && reg_hit(paddr);
  assign cmd_wr = wr_acc && paddr == SWR_OFS_CMD;
  assign code = pwdata[7:0];
  assign bit_value = pwdata[SWR_BIT_VALUE_POS]; // R11
  assign line_busy_flag = st_q != SWR_IDLE;
  assign accept_rst = cmd_wr && !line_busy_flag && code == SWR_CMD_RESET; // R01
  assign accept_bit = cmd_wr && !line_busy_flag && code == SWR_CMD_BIT; // R10
  assign refuse = cmd_wr && !accept_rst && !accept_bit; // R05 R15
  assign pc_wr = wr_acc && paddr == SWR_OFS_PORTCFG && !line_busy_flag;
  assign active = line_busy_flag;
  assign done = active && el_q == t_end_q;
  assign s1_hit = active && el_q == t_s1_q;
  assign s2_hit = st_q == SWR_RESET && el_q == t_s2_q;

  // ----------------------------------------------------------------
  // port timing bank
  // ----------------------------------------------------------------
  swr_param_bank u_bank (
    .clock(clock),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .wr_en(pc_wr),
    .ctrl(pwdata[7:0]),
    .overdrive_speed_select(cfg_q.ovd),
    .cur(cur)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= SWR_IDLE;
      el_q <= '0;
    end else if (clk_en) begin
      case (st_q)
        SWR_IDLE: begin
          el_q <= TW'(1);
          if (accept_rst) begin
            st_q <= SWR_RESET; // R01 R04
          end else if (accept_bit) begin
            st_q <= SWR_SLOT; // R10 R14
          end
        end
        SWR_RESET, SWR_SLOT: begin
          el_q <= el_q + TW'(1);
          if (done) begin
            st_q <= SWR_IDLE; // R03 R13
          end
        end
        default: begin
          st_q <= SWR_IDLE;
        end
      endcase
    end
  end

  // thresholds latched from current settings at command start
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      t_low_q <= '0;
      t_end_q <= '0;
      t_s1_q <= '0;
      t_s2_q <= '0;
    end else if (clk_en) begin
      if (accept_rst) begin // R09
        t_low_q <= cyc(swr_rstl_q(cur.rstl, cfg_q.ovd));
        t_end_q <= TW'(cyc(swr_rstl_q(cur.rstl, cfg_q.ovd)) << 1); // R03
        t_s1_q <= TW'(cyc(swr_rstl_q(cur.rstl, cfg_q.ovd)) + cyc(swr_msp_q(cur.msp, cfg_q.ovd)));
        t_s2_q <= TW'(cyc(swr_rstl_q(cur.rstl, cfg_q.ovd)) + cyc(cfg_q.ovd ? SWR_SI_OD_Q : SWR_SI_STD_Q));
      end else if (accept_bit) begin // R09
        if (bit_value) begin // R11
          t_low_q <= cyc(cfg_q.ovd ? SWR_W1L_OD_Q : SWR_W1L_STD_Q);
        end else begin
          t_low_q <= cyc(swr_w0l_q(cur.w0l, cfg_q.ovd));
        end
        t_end_q <= TW'(cyc(swr_w0l_q(cur.w0l, cfg_q.ovd)) + cyc(swr_rec0_q(cur.rec0))); // R13
        t_s1_q <= cyc(cfg_q.ovd ? SWR_MSR_OD_Q : SWR_MSR_STD_Q);
        t_s2_q <= '0;
      end
    end
  end

  // line drive low for the low phase, then released
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      line_oe_q <= 1'b0;
    end else if (clk_en) begin
      if (accept_rst || accept_bit) begin
        line_oe_q <= 1'b1; // R04 R14
      end else if (active && el_q >= t_low_q) begin
        line_oe_q <= 1'b0; // R18
      end
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      presence_pulse_flag_q <= 1'b0;
      short_detect_flag_q <= 1'b0;
      single_bit_result_q <= 1'b0;
    end else if (clk_en) begin
      if (st_q == SWR_RESET && s1_hit) begin
        presence_pulse_flag_q <= !line_in; // R02 R19
      end
      if (s2_hit) begin
        short_detect_flag_q <= !line_in; // R02 R19
      end
      if (st_q == SWR_SLOT && s1_hit) begin
        single_bit_result_q <= line_in; // R12 R13
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
      ptr_q <= SWR_PTR_STATUS;
    end else if (clk_en) begin
      if (cmd_wr) begin
        ack_q <= !refuse; // R05 R15
      end
      if (accept_rst || accept_bit) begin
        ptr_q <= SWR_PTR_STATUS; // R08 R16
      end else if (pc_wr) begin
        ptr_q <= SWR_PTR_PORTCFG;
      end else if (wr_acc && paddr == SWR_OFS_CONFIG) begin
        ptr_q <= SWR_PTR_CONFIG;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration and pullups
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q <= SWR_CFG_RESET;
    end else if (clk_en && wr_acc && paddr == SWR_OFS_CONFIG) begin
      cfg_q.active_pullup_enable <= pwdata[SWR_CFG_APU];
      cfg_q.strong_pullup_enable <= pwdata[SWR_CFG_SPU];
      cfg_q.ovd <= pwdata[SWR_CFG_OVD];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      apu_q <= 1'b0;
      spu_q <= 1'b0;
      weak_pullup_resistance_q <= SWR_WEAK_PULLUP_RESISTANCE_RST;
    end else if (clk_en) begin
      apu_q <= cfg_q.active_pullup_enable && active && !line_oe_q; // R09
      spu_q <= cfg_q.strong_pullup_enable && !active; // R09
      weak_pullup_resistance_q <= cur.weak_pullup_resistance; // R09
    end
  end

  // ----------------------------------------------------------------
  // interrupts: sticky, write one to clear, set wins
  // ----------------------------------------------------------------
  always_comb begin
    ev = '0;
    ev[SWR_IRQ_DONE] = done && clk_en;
    ev[SWR_IRQ_REFUSED] = refuse;
    ev[SWR_IRQ_PRESENCE] = st_q == SWR_RESET && s1_hit && !line_in && clk_en;
    ev[SWR_IRQ_SHORT] = s2_hit && !line_in && clk_en;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
    end else if (clk_en) begin
      if (wr_acc && paddr == SWR_OFS_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~pwdata[SWR_IRQ_W-1:0]) | ev;
      end else begin
        irq_stat_q <= irq_stat_q | ev;
      end
      if (wr_acc && paddr == SWR_OFS_IRQ_MASK) begin
        irq_mask_q <= pwdata[SWR_IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // read data, registered in the setup phase
  // ----------------------------------------------------------------
  always_comb begin
    status_w = '0;
    status_w[SWR_ST_BUSY] = line_busy_flag;
    status_w[SWR_ST_PRESENCE] = presence_pulse_flag_q;
    status_w[SWR_ST_SHORT] = short_detect_flag_q;
    status_w[SWR_ST_ACK] = ack_q;
    status_w[SWR_ST_SBR] = single_bit_result_q;
    portcfg_w = {15'h0, cur};
    case (ptr_q)
      SWR_PTR_CONFIG: ptr_w = {28'h0, cfg_q.ovd, cfg_q.strong_pullup_enable, 1'b0, cfg_q.active_pullup_enable};
      SWR_PTR_PORTCFG: ptr_w = portcfg_w;
      default: ptr_w = status_w;
    endcase
    case (paddr)
      SWR_OFS_STATUS: rd_w = status_w;
      SWR_OFS_CONFIG: rd_w = {28'h0, cfg_q.ovd, cfg_q.strong_pullup_enable, 1'b0, cfg_q.active_pullup_enable};
      SWR_OFS_PORTCFG: rd_w = portcfg_w;
      SWR_OFS_RDPTR: rd_w = {30'h0, ptr_q};
      SWR_OFS_PTRDATA: rd_w = ptr_w;
      SWR_OFS_IRQ_STAT: rd_w = {28'h0, irq_stat_q};
      SWR_OFS_IRQ_MASK: rd_w = {28'h0, irq_mask_q};
      default: rd_w = '0;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prdata_q <= '0;
    end else if (clk_en && psel && !penable) begin
      prdata_q <= pwrite ? 32'h0 : rd_w;
    end
  end

  assign line_out = 1'b0;
  assign line_oe = line_oe_q;
  assign active_pullup_drive = apu_q;
  assign strong_pullup_drive = spu_q;
  assign weak_pullup_select = weak_pullup_resistance_q;
  assign irq = |(irq_stat_q & irq_mask_q);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  localparam int LAT_MAX = SWR_START_LAT_CYC;

  default clocking cb @(posedge clock iff clk_en);
  endclocking
  default disable iff (!reset_n);

  busy_refuse_a: assert property ( // R05
    cmd_wr && line_busy_flag |=> !ack_q && $stable(t_end_q) && irq_stat_q[SWR_IRQ_REFUSED])
    else $error("command taken while busy");
  bit_refuse_a: assert property ( // R15
    cmd_wr && line_busy_flag && code == SWR_CMD_BIT |=> $stable(t_low_q) && $stable(t_s1_q))
    else $error("bit command altered slot while busy");
  reset_start_a: assert property ( // R04
    accept_rst |-> ##[1:LAT_MAX] (line_oe_q && st_q == SWR_RESET))
    else $error("reset activity late");
  slot_start_a: assert property ( // R14
    accept_bit |=> line_oe_q && st_q == SWR_SLOT && el_q == TW'(1))
    else $error("slot activity late");
  reset_len_a: assert property ( // R03
    $rose(line_busy_flag) && st_q == SWR_RESET |-> t_end_q == TW'(t_low_q << 1))
    else $error("reset busy not twice low time");
  reset_low_a: assert property ( // R18
    st_q == SWR_RESET && $fell(line_oe_q) |-> el_q == t_low_q + TW'(1))
    else $error("reset low phase wrong length");
  presence_upd_a: assert property ( // R19
    st_q == SWR_RESET && s1_hit |=> presence_pulse_flag_q == !$past(line_in))
    else $error("presence flag not updated");
  short_upd_a: assert property ( // R02
    s2_hit |=> short_detect_flag_q == !$past(line_in))
    else $error("short flag not updated");
  sbr_upd_a: assert property ( // R12
    st_q == SWR_SLOT && s1_hit |=> single_bit_result_q == $past(line_in))
    else $error("bit result not updated");
  slot_one_a: assert property ( // R11
    accept_bit && bit_value |=> t_low_q == cyc(cfg_q.ovd ? SWR_W1L_OD_Q : SWR_W1L_STD_Q))
    else $error("write-one low time wrong");
  ptr_status_a: assert property ( // R16
    accept_rst || accept_bit |=> ptr_q == SWR_PTR_STATUS)
    else $error("read pointer not on status");

  reset_presence_c: cover property (st_q == SWR_RESET && s1_hit && !line_in);
  slot_read_one_c: cover property (st_q == SWR_SLOT && s1_hit && line_in);
  refused_cmd_c: cover property (cmd_wr && line_busy_flag);

endmodule : swr_top

/* dv/swr_line_model.sv */
/*
  swr_line_model: slave devices on the single-wire line.
  assumes line_oe is the master pull-down; a weak pullup makes a free line high.
*/
`timescale 1ns/1ps
module swr_line_model (
  input wire logic clock,
  input wire logic line_oe,
  input wire logic presence_en,
  input wire logic short_en,
  input wire logic bit_val,
  output logic line_in
);
  // ----------------------------------------
  // slave answers
  // ----------------------------------------
  int low_cnt = 0;
  int rel_cnt = 1000;
  int last_low = 0;
  logic pull;
  always @(posedge clock) begin
    if (line_oe) begin
      low_cnt <= low_cnt + 1;
      rel_cnt <= 0;
    end else begin
      if (low_cnt != 0) last_low <= low_cnt;
      low_cnt <= 0;
      rel_cnt <= rel_cnt + 1;
    end
  end
  // presence after a long low, zero bit after a short low, or a shorted line
  assign pull = short_en || (presence_en && last_low > 1000 && rel_cnt >= 40 && rel_cnt < 400)
    || (!bit_val && last_low < 100 && rel_cnt < 20);
  assign line_in = !(line_oe || pull);
endmodule : swr_line_model

/* dv/swr_tb_top.sv */
/*
  bench for swr_top: apb master, line model, self checks.
  assumes CYC_PER_QUS=1 and default port timing codes, except the overdrive reset-low code, which is written to 0.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module single_wire_reset_and_bit_slot_tb_top import swr_pkg::*;;
  localparam int RSTL = 2240;
  logic clock = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pres = 1, shrt = 0, bv = 1, ce = 1;
  logic [2:0] pu;
  logic [7:0] paddr = 8'h00;
  logic [7:0] rnd = 8'h3e;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, err_q, line_in, line_oe, irq;
  int errors = 0, samples_checked = 0, cyc = 0, t, run = 0, low = 0;
  always #12.5 clock = ~clock;
  swr_top #(.CYC_PER_QUS(1)) uut (.clock(clock), .reset_n(reset_n), .clk_en(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .line_in(line_in), .line_out(), .line_oe(line_oe), .active_pullup_drive(pu[2]),
    .strong_pullup_drive(pu[1]), .weak_pullup_select(pu[0]), .irq(irq));
  swr_line_model lm (.clock(clock), .line_oe(line_oe), .presence_en(pres), .short_en(shrt),
    .bit_val(bv), .line_in(line_in));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  always @(posedge clock) begin
    cyc++;
    if (line_oe) run <= run + int'(ce);
    else if (run != 0) begin
      low <= run;
      run <= 0;
    end
    if (cyc == 30000) begin
      errors++;
      print_verdict();
    end
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    ce <= !w;
    do begin
      @(posedge clock);
      ce <= 1'b1;
    end while (pready !== 1'b1);
    r = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  task automatic cmd(input logic [31:0] c, input int busy, input int lo);
    apb(1'b1, SWR_OFS_CMD, c);
    apb(1'b0, SWR_OFS_STATUS, 0);
    `CHK({r[SWR_ST_ACK], r[SWR_ST_BUSY]}, 2'b11)
    apb(1'b1, SWR_OFS_CMD, c ^ 32'h33);
    apb(1'b0, SWR_OFS_STATUS, 0);
    `CHK({r[SWR_ST_ACK], r[SWR_ST_BUSY]}, 2'b01)
    t = 10;
    while (irq !== 1'b1 && t < 6000) begin
      @(posedge clock);
      t++;
    end
    `CHK(t >= busy - 2 && t <= busy + 2, 1'b1)
    `CHK(low, lo)
    apb(1'b0, SWR_OFS_RDPTR, 0);
    `CHK(r[1:0], SWR_PTR_STATUS)
    apb(1'b0, SWR_OFS_IRQ_STAT, 0);
    `CHK(r[1:0], 2'b11)
    apb(1'b1, SWR_OFS_IRQ_STAT, 32'h3);
    `CHK(irq, 1'b0)
    apb(1'b0, SWR_OFS_STATUS, 0);
  endtask : cmd
  task print_verdict;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  // ----------------------------------------
  // main sequence, next command only after done; each cmd call also writes one refused command while busy
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    apb(1'b0, SWR_OFS_CONFIG, 0);
    `CHK(r[3:0], 4'h0)
    `CHK(pu, 3'b001)
    apb(1'b0, 8'h40, 0);
    `CHK({err_q, r}, {1'b1, 32'h0})
    apb(1'b1, SWR_OFS_IRQ_MASK, 32'h1);
    cmd({24'h0, SWR_CMD_RESET}, 2 * RSTL, RSTL);
    `CHK(r[2:1], 2'b01)
    shrt <= 1'b1;
    cmd({24'h0, SWR_CMD_RESET}, 2 * RSTL, RSTL);
    `CHK(r[2:1], 2'b11)
    shrt <= 1'b0;
    pres <= 1'b0;
    apb(1'b1, SWR_OFS_PORTCFG, 32'h10);
    apb(1'b1, SWR_OFS_CONFIG, 32'h8);
    cmd({24'h0, SWR_CMD_RESET}, 352, 176);
    `CHK(r[2:1], 2'b00)
    apb(1'b1, SWR_OFS_CONFIG, 32'h5);
    apb(1'b0, SWR_OFS_PORTCFG, 0);
    `CHK(r[16:13], SWR_RSTL_RST)
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      bv <= rnd[0];
      cmd({16'h0, i[0], rnd[6:0], SWR_CMD_BIT}, 277, i[0] ? 32 : 256);
      `CHK(r[SWR_ST_SBR], i[0] & rnd[0])
      `CHK(pu, 3'b011)
    end
    print_verdict();
  end
endmodule : single_wire_reset_and_bit_slot_tb_top
